//--- shared/dsau_pkg.sv
// constants for the data space access unit
// assumes a 16-bit core with byte-granular data addresses
package dsau_pkg;
  // ==========================================
  // widths and spaces
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam logic [15:0] SP_RESET = 16'h0800;
  localparam logic [15:0] SFR_TOP = 16'h0800;
  localparam logic [15:0] NEAR_TOP = 16'h1fff;
  localparam int unsigned NEAR_W = 13;
  localparam logic [15:0] X_BASE_DEF = 16'h0800;
  localparam logic [15:0] Y_BASE_DEF = 16'h1800;
  localparam logic [15:0] Y_END_DEF = 16'h1fff;
  localparam logic [15:0] BOOT_SECURE_RAM_BASE_DEF = 16'h0800;
  localparam logic [15:0] BOOT_SECURE_RAM_END_DEF = 16'h08ff;
  localparam logic [15:0] SEGMENT_SECURE_RAM_BASE_DEF = 16'h0900;
  localparam logic [15:0] SEGMENT_SECURE_RAM_END_DEF = 16'h09ff;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;

  // ==========================================
  // enumerations
  typedef enum logic [1:0] {
    TRAP_NONE = 2'b00,
    TRAP_ADDR = 2'b01,
    TRAP_STACK = 2'b10,
    TRAP_SECURE = 2'b11
  } trap_e;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_READ = 3'b001,
    OP_WRITE = 3'b010,
    OP_PUSH = 3'b011,
    OP_POP = 3'b100,
    OP_CALL_PUSH = 3'b101,
    OP_EXC_PUSH = 3'b110,
    OP_ACC_WB = 3'b111
  } op_e;

  typedef enum logic [1:0] {
    MODE_PLAIN = 2'b00,
    MODE_MODULO = 2'b01,
    MODE_BITREV = 2'b10
  } amode_e;
endpackage

//--- rtl/data_space_access_unit.sv
// data space access unit: routes and checks core data-space accesses
// assumes the execution unit holds requests one cycle and reacts to trap pulses
// Behaviour
// - all writes go over the X write bus
// - bit-reverse on X writes only; modulo everywhere
// - MAC prefetch: two pointers X, two Y
// - accumulator write-back targets whole space over X
// - unimplemented address reads return zero, no error
// - prefetch pointer in wrong space returns zero
// - 16-bit byte addresses, 64 Kbyte space
// - byte read selects byte by bit zero
// - byte write strobes only matching lane
// - post-increment by one byte, two word
// - odd word access traps; write suppressed
// - byte load keeps register high byte
// - 13-bit near field; 16-bit move field
// - stack grows up: push post-inc, pop pre-dec
// - call push zeroes upper PC high byte
// - exception push merges status low byte
// - stack limit unreset, bit zero zero
// - push at limit ok, next push traps
// - stack address below 0x0800 traps
// - secure RAM segments gated by code segment
// - stack pointer bit zero always zero
// - stack pointer resets to 0x0800
`timescale 1ns/1ps
`default_nettype none
module data_space_access_unit #(
  parameter logic [15:0] Y_BASE = dsau_pkg::Y_BASE_DEF,
  parameter logic [15:0] Y_END = dsau_pkg::Y_END_DEF,
  parameter logic [15:0] MEM_TOP = dsau_pkg::Y_END_DEF,
  parameter logic [15:0] BOOT_SECURE_RAM_BASE = dsau_pkg::BOOT_SECURE_RAM_BASE_DEF,
  parameter logic [15:0] BOOT_SECURE_RAM_END = dsau_pkg::BOOT_SECURE_RAM_END_DEF,
  parameter logic [15:0] SEGMENT_SECURE_RAM_BASE = dsau_pkg::SEGMENT_SECURE_RAM_BASE_DEF,
  parameter logic [15:0] SEGMENT_SECURE_RAM_END = dsau_pkg::SEGMENT_SECURE_RAM_END_DEF
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire dsau_pkg::op_e req_op,
  input wire logic req_byte,
  input wire logic [15:0] req_addr,
  input wire logic req_use_sp,
  input wire dsau_pkg::amode_e req_mode,
  input wire logic [15:0] req_modulo_end,
  input wire logic req_near,
  input wire logic [15:0] req_wdata,
  input wire logic [15:0] req_dest_old,
  input wire logic [22:0] pc_value,
  input wire logic [7:0] status_low_byte,
  input wire logic mac_valid,
  input wire logic [15:0] x_prefetch_pointer_a,
  input wire logic [15:0] y_prefetch_pointer_a,
  input wire logic mac_use_b,
  input wire logic [15:0] x_prefetch_pointer_b,
  input wire logic [15:0] y_prefetch_pointer_b,
  input wire logic sp_wr,
  input wire logic [15:0] sp_wdata,
  input wire logic limit_wr,
  input wire logic [15:0] limit_wdata,
  input wire logic protect_en,
  input wire logic exec_in_boot,
  input wire logic exec_in_secure,
  input wire logic [15:0] mem_x_rdata,
  input wire logic [15:0] mem_y_rdata,
  output logic [15:0] mem_x_addr,
  output logic mem_x_rd,
  output logic [15:0] mem_x_wdata,
  output logic [1:0] mem_x_wstrb,
  output logic [15:0] mem_y_addr,
  output logic mem_y_rd,
  output logic [15:0] rdata,
  output logic [15:0] x_prefetch_data,
  output logic [15:0] y_prefetch_data,
  output logic [15:0] ptr_next,
  output logic [15:0] stack_pointer_reg,
  output logic [15:0] stack_limit_reg,
  output logic trap_req,
  output dsau_pkg::trap_e trap_code
);
  // ==========================================
  // reset release
  logic rst_a_q;
  logic rst_n_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_a_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_n_q <= rst_a_q;
    end
  end

  // ==========================================
  // helpers
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [15:0] bitrev(input logic [15:0] a);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 1; i < 16; i++) r[i] = a[16 - i];
    bitrev = r;
  endfunction

  function automatic logic [7:0] lane_pick(input logic [15:0] w, input logic sel);
    lane_pick = sel ? w[15:8] : w[7:0];
  endfunction

  // ==========================================
  // address formation
  logic is_push;
  logic is_pop;
  logic is_wr;
  logic [15:0] sp_pop;
  logic [15:0] ea;
  logic [15:0] step;
  logic word_acc;
  logic [15:0] limit_q;
  logic push_at_limit_q;
  logic [15:0] ptr_next_d;
  logic [15:0] xp;
  logic x_ok;
  assign is_push = req_op inside {dsau_pkg::OP_PUSH, dsau_pkg::OP_CALL_PUSH,
                                  dsau_pkg::OP_EXC_PUSH};
  assign is_pop = req_op == dsau_pkg::OP_POP;
  assign is_wr = is_push || req_op inside {dsau_pkg::OP_WRITE, dsau_pkg::OP_ACC_WB};
  assign sp_pop = stack_pointer_reg - dsau_pkg::STEP_WORD;
  assign word_acc = !req_byte || is_push || is_pop;
  assign step = word_acc ? dsau_pkg::STEP_WORD : dsau_pkg::STEP_BYTE;

  always_comb begin
    ea = req_addr;
    if (is_push) begin
      ea = stack_pointer_reg;
    end else if (is_pop) begin
      ea = sp_pop;
    end else if (req_near) begin
      ea = {3'b000, req_addr[dsau_pkg::NEAR_W-1:0]};
    end else if (req_mode == dsau_pkg::MODE_BITREV && req_op == dsau_pkg::OP_WRITE) begin
      ea = bitrev(req_addr);
    end
  end

  // pointer update; modulo reloads the request address at or past the end, on any space; bit-reverse only on X writes
  always_comb begin
    ptr_next_d = ea + step;
    if (req_mode == dsau_pkg::MODE_MODULO && ea >= req_modulo_end) begin
      ptr_next_d = req_addr;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) ptr_next <= 16'h0000;
    else if (req_valid) ptr_next <= ptr_next_d;
  end

  // ==========================================
  // checks
  logic misalign;
  logic stack_ea;
  logic stk_err;
  logic sec_err;
  logic impl;
  assign misalign = word_acc && ea[0];
  assign stack_ea = req_use_sp || is_push || is_pop;
  assign stk_err = stack_ea && ((ea < dsau_pkg::SFR_TOP)
                   || (is_push && ea > limit_q));
  assign sec_err = protect_en &&
                   ((in_range(ea, BOOT_SECURE_RAM_BASE, BOOT_SECURE_RAM_END) && !exec_in_boot) ||
                    (in_range(ea, SEGMENT_SECURE_RAM_BASE, SEGMENT_SECURE_RAM_END) && !exec_in_secure));
  assign impl = ea <= MEM_TOP;

  // ==========================================
  // stack pointer and limit
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      stack_pointer_reg <= dsau_pkg::SP_RESET;
    end else if (sp_wr) begin
      stack_pointer_reg <= {sp_wdata[15:1], 1'b0};
    end else if (req_valid && is_push) begin
      stack_pointer_reg <= {ea[15:1] + 15'h0001, 1'b0};
    end else if (req_valid && is_pop) begin
      stack_pointer_reg <= {sp_pop[15:1], 1'b0};
    end
  end

  // limit has no reset: software must load it before relying on it
  always_ff @(posedge core_clk) begin
    if (limit_wr) limit_q <= {limit_wdata[15:1], 1'b0};
  end
  assign stack_limit_reg = limit_q;

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) push_at_limit_q <= 1'b0;
    else if (req_valid && is_push) push_at_limit_q <= (ea == limit_q);
  end

  // ==========================================
  // X bus: the only write path; a prefetch borrows its read address
  logic [15:0] wword;
  always_comb begin
    unique case (req_op)
      dsau_pkg::OP_CALL_PUSH: wword = {9'h000, pc_value[22:16]};
      dsau_pkg::OP_EXC_PUSH: wword = {status_low_byte, 1'b0, pc_value[22:16]};
      default: wword = req_byte ? {req_wdata[7:0], req_wdata[7:0]} : req_wdata;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mem_x_addr <= 16'h0000;
      mem_x_rd <= 1'b0;
      mem_x_wdata <= 16'h0000;
      mem_x_wstrb <= 2'b00;
    end else begin
      mem_x_addr <= mac_valid ? {xp[15:1], 1'b0} : {ea[15:1], 1'b0};
      mem_x_rd <= mac_valid ? x_ok : (req_valid && !is_wr && impl && !sec_err);
      mem_x_wdata <= wword;
      if (req_valid && is_wr && !misalign && !stk_err && !sec_err && impl) begin
        mem_x_wstrb <= word_acc ? 2'b11 : (ea[0] ? 2'b10 : 2'b01);
      end else begin
        mem_x_wstrb <= 2'b00;
      end
    end
  end

  // read return, two cycles after the request
  logic rd_pend_q;
  logic rd_ok_q;
  logic rd_byte_q;
  logic rd_sel_q;
  logic [7:0] rd_hi_q;
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rd_pend_q <= 1'b0;
      rd_ok_q <= 1'b0;
      rd_byte_q <= 1'b0;
      rd_sel_q <= 1'b0;
      rd_hi_q <= 8'h00;
    end else begin
      rd_pend_q <= req_valid && !is_wr;
      rd_ok_q <= impl && !sec_err;
      rd_byte_q <= !word_acc;
      rd_sel_q <= ea[0];
      rd_hi_q <= req_dest_old[15:8];
    end
  end
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) rdata <= 16'h0000;
    else if (rd_pend_q && !rd_ok_q) rdata <= dsau_pkg::ZERO_WORD;
    else if (rd_pend_q && rd_byte_q) rdata <= {rd_hi_q, lane_pick(mem_x_rdata, rd_sel_q)};
    else if (rd_pend_q) rdata <= mem_x_rdata;
  end

  // ==========================================
  // MAC prefetch: X pointers read X, Y pointers read Y
  logic [15:0] yp;
  logic y_ok;
  logic x_ok_q;
  logic y_ok_q;
  assign xp = mac_use_b ? x_prefetch_pointer_b : x_prefetch_pointer_a;
  assign yp = mac_use_b ? y_prefetch_pointer_b : y_prefetch_pointer_a;
  assign x_ok = !in_range(xp, Y_BASE, Y_END) && xp <= MEM_TOP;
  assign y_ok = in_range(yp, Y_BASE, Y_END);
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mem_y_addr <= 16'h0000;
      mem_y_rd <= 1'b0;
      x_ok_q <= 1'b0;
      y_ok_q <= 1'b0;
    end else begin
      mem_y_addr <= {yp[15:1], 1'b0};
      mem_y_rd <= mac_valid && y_ok;
      x_ok_q <= mac_valid && x_ok;
      y_ok_q <= mac_valid && y_ok;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      x_prefetch_data <= 16'h0000;
      y_prefetch_data <= 16'h0000;
    end else begin
      x_prefetch_data <= x_ok_q ? mem_x_rdata : dsau_pkg::ZERO_WORD;
      y_prefetch_data <= y_ok_q ? mem_y_rdata : dsau_pkg::ZERO_WORD;
    end
  end

  // ==========================================
  // trap pulses; address error outranks stack error
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      trap_req <= 1'b0;
      trap_code <= dsau_pkg::TRAP_NONE;
    end else begin
      trap_req <= req_valid && (misalign || stk_err || sec_err);
      if (req_valid && misalign) trap_code <= dsau_pkg::TRAP_ADDR;
      else if (req_valid && stk_err) trap_code <= dsau_pkg::TRAP_STACK;
      else if (req_valid && sec_err) trap_code <= dsau_pkg::TRAP_SECURE;
      else trap_code <= dsau_pkg::TRAP_NONE;
    end
  end

  // ==========================================
  // checks on behaviour
  a_sp_reset_val: assert property (@(posedge core_clk) $rose(rst_n_q) |->
    stack_pointer_reg == dsau_pkg::SP_RESET) else $error("sp reset value wrong");
  a_sp_aligned: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    !stack_pointer_reg[0]) else $error("sp odd");
  a_limit_aligned: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    limit_wr |=> !stack_limit_reg[0]) else $error("limit odd");
  a_misalign_trap: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    req_valid && misalign |=> trap_req && trap_code == dsau_pkg::TRAP_ADDR && mem_x_wstrb == 2'b00)
    else $error("misaligned access not trapped");
  a_byte_lane: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    req_valid && req_op == dsau_pkg::OP_WRITE && req_byte && !sec_err && !stk_err && impl
    |=> mem_x_wstrb == ($past(ea[0]) ? 2'b10 : 2'b01)) else $error("byte lane wrong");
  a_push_step: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    req_valid && is_push && !sp_wr |=> stack_pointer_reg == $past(stack_pointer_reg) + 16'h0002)
    else $error("push step wrong");
  a_under_trap: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    req_valid && (is_push || is_pop) && ea < dsau_pkg::SFR_TOP |=> trap_req)
    else $error("underflow missed");
  a_trap_pulse: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    trap_req |-> trap_code != dsau_pkg::TRAP_NONE) else $error("trap without code");
  a_prefetch_zero: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    mac_valid && !y_ok |=> ##1 y_prefetch_data == 16'h0000) else $error("bad y prefetch");
  a_call_msb: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    req_valid && req_op == dsau_pkg::OP_CALL_PUSH |=> mem_x_wdata[15:8] == 8'h00)
    else $error("call high byte set");
  c_push: cover property (@(posedge core_clk) req_valid && is_push);
  c_limit_hit: cover property (@(posedge core_clk) push_at_limit_q && req_valid && is_push);
  c_mac: cover property (@(posedge core_clk) mac_valid && x_ok && y_ok);
  c_byte_rd: cover property (@(posedge core_clk) req_valid && req_op == dsau_pkg::OP_READ && req_byte);
endmodule
`default_nettype wire

//--- tb/dsau_mem_model.sv
// partner model: data memory behind the access unit, one word array for X and Y
// assumes read data is wanted while the read strobe stands, writes land on the clock
`timescale 1ns/1ps
`default_nettype none
module dsau_mem_model (
  input wire logic core_clk,
  input wire logic [15:0] mem_x_addr,
  input wire logic mem_x_rd,
  input wire logic [15:0] mem_x_wdata,
  input wire logic [1:0] mem_x_wstrb,
  input wire logic [15:0] mem_y_addr,
  input wire logic mem_y_rd,
  output logic [15:0] mem_x_rdata,
  output logic [15:0] mem_y_rdata
);
  // ==========================================
  // storage, preloaded with an address-derived pattern
  logic [15:0] mem_q [0:32767];
  logic [15:0] x_last_q;
  logic [15:0] y_last_q;
  initial begin
    for (int i = 0; i < 32768; i++) begin
      mem_q[i] = 16'(i) ^ 16'h5a5a;
    end
    x_last_q = 16'h0000;
    y_last_q = 16'h0000;
  end
  always @(posedge core_clk) begin
    if (mem_x_wstrb[0]) begin
      mem_q[mem_x_addr[15:1]][7:0] <= mem_x_wdata[7:0];
    end
    if (mem_x_wstrb[1]) begin
      mem_q[mem_x_addr[15:1]][15:8] <= mem_x_wdata[15:8];
    end
    x_last_q <= mem_x_rdata;
    y_last_q <= mem_y_rdata;
  end
  // ==========================================
  // idle buses toggle so a stale value is never mistaken for data
  assign mem_x_rdata = mem_x_rd ? mem_q[mem_x_addr[15:1]] : ~x_last_q;
  assign mem_y_rdata = mem_y_rd ? mem_q[mem_y_addr[15:1]] : ~y_last_q;
endmodule
`default_nettype wire

//--- tb/data_space_access_unit_tb.sv
// testbench for the data space access unit: directed scenarios, self checking
// assumes the memory model answers reads in the cycle the read strobe stands
`timescale 1ns/1ps
`default_nettype none
module data_space_access_unit_tb;
  // ==========================================
  // signals
  logic core_clk = 1'b0;
  logic arst_n, req_valid, req_byte, req_use_sp, req_near, mac_valid, mac_use_b;
  logic sp_wr, limit_wr, protect_en, exec_in_boot, exec_in_secure;
  dsau_pkg::op_e req_op;
  dsau_pkg::amode_e req_mode;
  logic [15:0] req_addr, req_modulo_end, req_wdata, req_dest_old, sp_wdata, limit_wdata;
  logic [15:0] x_prefetch_pointer_a, y_prefetch_pointer_a, x_prefetch_pointer_b;
  logic [15:0] y_prefetch_pointer_b, mem_x_rdata, mem_y_rdata, mem_x_addr, mem_x_wdata;
  logic [15:0] mem_y_addr, rdata, x_prefetch_data, y_prefetch_data, ptr_next;
  logic [15:0] stack_pointer_reg, stack_limit_reg, nxt, trp, w;
  logic [22:0] pc_value;
  logic [7:0] status_low_byte;
  logic [1:0] mem_x_wstrb;
  logic mem_x_rd, mem_y_rd, trap_req;
  dsau_pkg::trap_e trap_code;
  int err_total = 0;
  int comparisons = 0;
  // pulse bit above the two-bit trap code
  localparam logic [15:0] T_NONE = 16'h0000;
  localparam logic [15:0] T_ADDR = 16'h0005;
  localparam logic [15:0] T_STACK = 16'h0006;
  localparam logic [15:0] T_SECURE = 16'h0007;
  always #5 core_clk = ~core_clk;
  data_space_access_unit DUT (.core_clk, .arst_n, .req_valid, .req_op, .req_byte, .req_addr,
    .req_use_sp, .req_mode, .req_modulo_end, .req_near, .req_wdata, .req_dest_old, .pc_value,
    .status_low_byte, .mac_valid, .x_prefetch_pointer_a, .y_prefetch_pointer_a, .mac_use_b,
    .x_prefetch_pointer_b, .y_prefetch_pointer_b, .sp_wr, .sp_wdata, .limit_wr, .limit_wdata,
    .protect_en, .exec_in_boot, .exec_in_secure, .mem_x_rdata, .mem_y_rdata, .mem_x_addr,
    .mem_x_rd, .mem_x_wdata, .mem_x_wstrb, .mem_y_addr, .mem_y_rd, .rdata, .x_prefetch_data,
    .y_prefetch_data, .ptr_next, .stack_pointer_reg, .stack_limit_reg, .trap_req, .trap_code);
  dsau_mem_model mem (.core_clk, .mem_x_addr, .mem_x_rd, .mem_x_wdata, .mem_x_wstrb,
    .mem_y_addr, .mem_y_rd, .mem_x_rdata, .mem_y_rdata);
  // ==========================================
  // shared tasks
  function automatic logic [15:0] iw(input logic [15:0] a);
    return {1'b0, a[15:1]} ^ 16'h5a5a;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one request, held for one edge; returns just after its first answer cycle
  task automatic req(input dsau_pkg::op_e op, input logic b, input logic [15:0] a,
                     input logic [15:0] d);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_byte <= b;
    req_addr <= a;
    req_wdata <= d;
    @(posedge core_clk);
    req_valid <= 1'b0;
    #1 trp = {13'h0000, trap_req, trap_code};
    nxt = ptr_next;
  endtask
  task automatic rd(input dsau_pkg::op_e op, input logic b, input logic [15:0] a,
                    input logic [15:0] e);
    req(op, b, a, 16'h0000);
    @(posedge core_clk);
    #1 chk(rdata, e);
  endtask
  task automatic regw(input logic lim, input logic [15:0] v);
    @(posedge core_clk);
    sp_wr <= !lim;
    limit_wr <= lim;
    sp_wdata <= v;
    limit_wdata <= v;
    @(posedge core_clk);
    sp_wr <= 1'b0;
    limit_wr <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  // the unused pointer pair points elsewhere so a wrong pair select shows
  task automatic mac(input logic b, input logic [15:0] xp, input logic [15:0] yp,
                     input logic [15:0] ex, input logic [15:0] ey);
    @(posedge core_clk);
    mac_valid <= 1'b1;
    mac_use_b <= b;
    x_prefetch_pointer_a <= b ? 16'h0c00 : xp;
    x_prefetch_pointer_b <= b ? xp : 16'h0c00;
    y_prefetch_pointer_a <= b ? 16'h1c00 : yp;
    y_prefetch_pointer_b <= b ? yp : 16'h1c00;
    @(posedge core_clk);
    mac_valid <= 1'b0;
    @(posedge core_clk);
    #1 chk(x_prefetch_data, ex);
    chk(y_prefetch_data, ey);
  endtask
  task automatic sec(input logic b, input logic s, input logic [15:0] a, input logic [15:0] e);
    @(posedge core_clk);
    protect_en <= 1'b1;
    exec_in_boot <= b;
    exec_in_secure <= s;
    req(dsau_pkg::OP_WRITE, 1'b0, a, 16'h9999);
    chk(trp, e);
  endtask
  // ==========================================
  // scenarios
  task automatic t_basic;
    chk(stack_pointer_reg, 16'h0800);
    chk({15'h0000, trap_req}, 16'h0000);
    req(dsau_pkg::OP_WRITE, 1'b0, 16'h0a10, 16'hbeef);
    chk({14'h0000, mem_x_wstrb}, 16'h0003);
    chk(mem_x_wdata, 16'hbeef);
    chk(nxt, 16'h0a12);
    rd(dsau_pkg::OP_READ, 1'b0, 16'h0a10, 16'hbeef);
    req(dsau_pkg::OP_ACC_WB, 1'b0, 16'h1810, 16'h1234);
    chk(mem_x_addr, 16'h1810);
    rd(dsau_pkg::OP_READ, 1'b0, 16'h1810, 16'h1234);
    rd(dsau_pkg::OP_READ, 1'b0, 16'hfffe, 16'h0000);
    chk(trp, T_NONE);
    @(posedge core_clk);
    req_mode <= dsau_pkg::MODE_BITREV;
    req(dsau_pkg::OP_WRITE, 1'b0, 16'h2000, 16'h2222);
    chk(mem_x_addr, 16'h0008);
    req(dsau_pkg::OP_READ, 1'b0, 16'h2000, 16'h0000);
    chk(mem_x_addr, 16'h2000);
    @(posedge core_clk);
    req_mode <= dsau_pkg::MODE_MODULO;
    req_modulo_end <= 16'h0a50;
    req(dsau_pkg::OP_WRITE, 1'b0, 16'h0a50, 16'h3333);
    chk(nxt, 16'h0a50);
    @(posedge core_clk);
    req_mode <= dsau_pkg::MODE_PLAIN;
    req_near <= 1'b1;
    rd(dsau_pkg::OP_READ, 1'b0, 16'he010, iw(16'h0010));
    @(posedge core_clk);
    req_near <= 1'b0;
    $display("test basic done");
  endtask
  task automatic t_byte;
    req(dsau_pkg::OP_WRITE, 1'b1, 16'h0a21, 16'h7777);
    chk({14'h0000, mem_x_wstrb}, 16'h0002);
    chk(nxt, 16'h0a22);
    rd(dsau_pkg::OP_READ, 1'b1, 16'h0a21, 16'hc377);
    w = iw(16'h0a20);
    rd(dsau_pkg::OP_READ, 1'b1, 16'h0a20, {8'hc3, w[7:0]});
    req(dsau_pkg::OP_WRITE, 1'b0, 16'h0a31, 16'h1111);
    chk(trp, T_ADDR);
    chk({14'h0000, mem_x_wstrb}, 16'h0000);
    @(posedge core_clk);
    #1 chk({15'h0000, trap_req}, 16'h0000);
    rd(dsau_pkg::OP_READ, 1'b0, 16'h0a30, iw(16'h0a30));
    req(dsau_pkg::OP_READ, 1'b0, 16'h0a33, 16'h0000);
    chk(trp, T_ADDR);
    $display("test byte done");
  endtask
  task automatic t_mac;
    mac(1'b0, 16'h0a00, 16'h1a00, iw(16'h0a00), iw(16'h1a00));
    mac(1'b1, 16'h1a00, 16'h0a00, 16'h0000, 16'h0000);
    $display("test mac done");
  endtask
  task automatic t_stack;
    regw(1'b0, 16'h0a41);
    chk(stack_pointer_reg, 16'h0a40);
    regw(1'b1, 16'h0a43);
    chk(stack_limit_reg, 16'h0a42);
    req(dsau_pkg::OP_PUSH, 1'b0, 16'h0a40, 16'h4444);
    chk(mem_x_addr, 16'h0a40);
    @(posedge core_clk);
    #1 chk(stack_pointer_reg, 16'h0a42);
    req(dsau_pkg::OP_PUSH, 1'b0, 16'h0a42, 16'h5555);
    chk(trp, T_NONE);
    req(dsau_pkg::OP_PUSH, 1'b0, 16'h0a44, 16'h6666);
    chk(trp, T_STACK);
    chk({14'h0000, mem_x_wstrb}, 16'h0000);
    regw(1'b0, 16'h0a42);
    rd(dsau_pkg::OP_POP, 1'b0, 16'h0a42, 16'h4444);
    chk(stack_pointer_reg, 16'h0a40);
    regw(1'b0, 16'h0a00);
    req(dsau_pkg::OP_CALL_PUSH, 1'b0, 16'h0a00, 16'h0000);
    chk(mem_x_wdata, 16'h007e);
    @(posedge core_clk);
    status_low_byte <= 8'h5c;
    req(dsau_pkg::OP_EXC_PUSH, 1'b0, 16'h0a04, 16'h0000);
    chk(mem_x_wdata, 16'h5c7e);
    regw(1'b0, 16'h0800);
    req(dsau_pkg::OP_POP, 1'b0, 16'h0800, 16'h0000);
    chk(trp, T_STACK);
    $display("test stack done");
  endtask
  task automatic t_secure;
    sec(1'b0, 1'b0, 16'h0810, T_SECURE);
    sec(1'b1, 1'b0, 16'h0810, T_NONE);
    sec(1'b1, 1'b0, 16'h0910, T_SECURE);
    sec(1'b0, 1'b1, 16'h0910, T_NONE);
    $display("test secure done");
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    {arst_n, req_valid, req_byte, req_use_sp, req_near, mac_valid, mac_use_b} = 7'h00;
    {sp_wr, limit_wr, protect_en, exec_in_boot, exec_in_secure} = 5'h00;
    req_op = dsau_pkg::OP_NONE;
    req_mode = dsau_pkg::MODE_PLAIN;
    {req_addr, req_modulo_end, req_wdata, sp_wdata, limit_wdata} = 80'h0;
    {x_prefetch_pointer_a, y_prefetch_pointer_a} = 32'h0;
    {x_prefetch_pointer_b, y_prefetch_pointer_b} = 32'h0;
    req_dest_old = 16'hc3c3;
    pc_value = 23'h7e_0000;
    status_low_byte = 8'h00;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_basic();
    t_byte();
    t_mac();
    t_stack();
    t_secure();
    summarize();
  end
  // the scenarios need about a hundred cycles; ten thousand means a hang
  initial begin
    #100000;
    err_total++;
    summarize();
  end
endmodule
`default_nettype wire
